// ### dv/spms_sync_source.sv
// Behavioural graphics source that drives composite sync pulses.
`timescale 1ns/1ps
module spms_sync_source (
    input  wire logic clk_sys,
    input  wire logic run,
    input  wire logic active_low,
    input  int        pulse_len,
    input  int        gap_len,
    output logic      csync,
    output logic      pulse_on
);
    int phase;

    // Pulse then gap, repeated while running; the line idles at its inactive level.
    always @(negedge clk_sys) begin
        if (!run || phase >= pulse_len + gap_len - 1) begin
            phase <= 0;
        end else begin
            phase <= phase + 1;
        end
    end

    // Polarity is applied here so the top sees either sense of pulse.
    assign pulse_on = run && (phase < pulse_len);
    assign csync    = pulse_on ^ active_low;
endmodule

// ### dv/test_sync_path_mux_separator.sv
// Self-checking bench for the sync path multiplexers and separator.
`timescale 1ns/1ps
module test_sync_path_mux_separator;
    import spms_pkg::*;
    logic       clk_sys, reset_n, csync_invert, green, vsync_in, coast_in, run;
    logic       hs, pon, hp, ss, cp, vp, vf;
    logic [7:0] ctl_12h, ctl_11h, thr, cnt;
    int         plen, glen, n_errors, check_count, n;
    spms_link_t dl, lo;

    spms_sync_source src (.clk_sys(clk_sys), .run(run), .active_low(csync_invert),
        .pulse_len(plen), .gap_len(glen), .csync(hs), .pulse_on(pon));
    spms_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .ctl_12h(ctl_12h),
        .ctl_11h(ctl_11h), .sep_threshold(thr), .csync_invert(csync_invert),
        .hsync_in(hs), .green_embedded_sync_input(green), .vsync_in(vsync_in),
        .coast_in(coast_in), .digital_link(dl), .link_out(lo), .hsync_path_out(hp),
        .sep_src_out(ss), .coast_path_out(cp), .vsync_path_out(vp),
        .vsync_found_out(vf), .sep_count_out(cnt));

    // ****************************************************************
    // Clock and shared tasks
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    // Bounded wait on the separator flag; running out ends the run.
    task automatic wait_vf(input logic lvl, input int lim);
        n = 0;
        while (vf !== lvl && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= lim) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, vf, lvl);
            close_out();
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Every combination of the four select bits; threshold at maximum keeps the flag low.
    task automatic t_mux();
        logic [2:0] el;
        thr = 8'hFF;
        green = 1'b1;
        vsync_in = 1'b1;
        dl = 3'b101;
        for (int i = 0; i < 16; i++) begin
            ctl_12h = {3'b000, i[3], 1'b0, i[2], i[1], 1'b0};
            ctl_11h = {4'h0, i[0], 3'b000};
            cycles(3);
            el = i[0] ? {i[3], ~i[2], 1'b1} : 3'b101;
            check(hp, i[3]);
            check(ss, i[3]);
            check(cp, i[1]);
            check(vp, !i[2]);
            check(lo, el);
        end
    endtask

    // A pulse a few ticks longer than 255 ticks must pin the count, then drain to zero.
    task automatic t_sat();
        ctl_12h = 8'h10;
        cycles(2100);
        check(cnt, 8'hFF);
        check(vf, 1'b0);
        green = 1'b0;
        cycles(2100);
        check(cnt, 8'h00);
    endtask

    // Line-rate pulses of two ticks never reach the threshold.
    task automatic t_short();
        logic [7:0] top;
        top = 8'h00;
        ctl_12h = 8'h00;
        thr = 8'h04;
        run = 1'b1;
        repeat (400) begin
            @(negedge clk_sys);
            if (cnt > top) top = cnt;
            check(vf, 1'b0);
        end
        check(top >= 8'h02 && top <= 8'h03, 1'b1);
        run = 1'b0;
        cycles(40);
        check(cnt, 8'h00);
    endtask

    // Long pulse: presence on the tick after T+1 counts, hold, absence on the tick after T quiet counts.
    task automatic t_detect(input logic inv);
        int up;
        csync_invert = inv;
        ctl_12h = 8'h04;
        plen = 400;
        glen = 800;
        cycles(2);
        run = 1'b1;
        wait_vf(1'b1, 200);
        up = n;
        check(up >= 32 && up <= 56, 1'b1);
        cycles(24);
        check(cnt, 8'h00);
        check(vp, 1'b1);
        cycles(372 - up);
        check(vf, 1'b1);
        cycles(2);
        wait_vf(1'b0, 100);
        check(n >= 23 && n <= 57, 1'b1);
        cycles(4);
        check(cnt, 8'h00);
        run = 1'b0;
    endtask

    // Main sequence: all inputs set at time zero, reset held for three cycles.
    initial begin
        reset_n = 1'b0;
        run = 1'b0;
        csync_invert = 1'b0;
        green = 1'b0;
        vsync_in = 1'b0;
        coast_in = 1'b0;
        ctl_12h = 8'h00;
        ctl_11h = 8'h00;
        thr = 8'hFF;
        dl = '0;
        plen = 16;
        glen = 64;
        n_errors = 0;
        check_count = 0;
        n = 0;
        cycles(3);
        reset_n = 1'b1;
        t_mux();
        t_sat();
        t_short();
        t_detect(1'b0);
        t_detect(1'b1);
        close_out();
    end
endmodule

// ### src/spms_pkg.sv
// Package with constants and carrier types for the sync path mux and separator.
package spms_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SYS_CLK_HZ        = 40_000_000;
    localparam int SEP_CLK_HZ        = 5_000_000;
    localparam int SEP_TICK_NS       = 200;
    localparam int SEP_DIV_COUNT     = SYS_CLK_HZ / SEP_CLK_HZ;
    localparam int SEP_DIV_W         = 3;

    // ****************************************************************
    // Separator counter
    // ****************************************************************
    localparam int          SEP_CNT_W   = 8;
    localparam logic [7:0]  SEP_CNT_MAX = 8'h00_FF;
    localparam logic [7:0]  SEP_CNT_MIN = 8'h00_00;
    localparam logic [7:0]  SEP_THR_RST = 8'h00_20;

    // ****************************************************************
    // Control bit positions
    // ****************************************************************
    localparam int CTL12_GREEN_SEL_BIT = 4;
    localparam int CTL12_VSYNC_SEL_BIT = 2;
    localparam int CTL12_COAST_SEL_BIT = 1;
    localparam int CTL11_ANALOG_SEL_BIT = 3;

    // Group of sync and timing signals from one link.
    typedef struct packed {
        logic hsync;
        logic vsync;
        logic data_en;
    } spms_link_t;

    typedef enum logic [0:0] {
        SPMS_SEEK,
        SPMS_HELD
    } spms_sep_state_t;

endpackage

// ### src/spms_separator.sv
// Vertical sync separator: counter based extraction from composite sync.
`timescale 1ns/1ps
module spms_separator
    import spms_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 tick,
    input  wire logic                 csync_active,
    input  wire logic [SEP_CNT_W-1:0] threshold,
    output logic                      vsync_found,
    output logic [SEP_CNT_W-1:0]      count
);

    spms_sep_state_t state_r;
    logic [SEP_CNT_W-1:0] cnt_r;
    logic                 hit;

    // ****************************************************************
    // Counter and state
    // ****************************************************************

    // Seeking: count above threshold declares presence; held: reaching it declares absence.
    assign hit = (state_r == SPMS_SEEK) ? (cnt_r > threshold) : (cnt_r >= threshold);

    // Counting only on ticks gives 200 ns per step with the 40 MHz system clock and its divide by 8.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= SPMS_SEEK;
            cnt_r   <= SEP_CNT_MIN;
        end else if (tick) begin
            case (state_r)
                SPMS_SEEK: begin
                    if (hit) begin
                        state_r <= SPMS_HELD; // [RQ7]
                        cnt_r   <= SEP_CNT_MIN; // [RQ8]
                    end else if (csync_active) begin
                        if (cnt_r != SEP_CNT_MAX) cnt_r <= cnt_r + 8'h00_01; // [RQ6] [RQ11]
                    end else if (cnt_r != SEP_CNT_MIN) begin
                        cnt_r <= cnt_r - 8'h00_01; // [RQ6] [RQ11]
                    end
                end
                SPMS_HELD: begin
                    if (hit) begin
                        state_r <= SPMS_SEEK; // [RQ9]
                        cnt_r   <= SEP_CNT_MIN; // [RQ10]
                    end else if (!csync_active) begin
                        if (cnt_r != SEP_CNT_MAX) cnt_r <= cnt_r + 8'h00_01; // [RQ8] [RQ11]
                    end else begin
                        cnt_r <= SEP_CNT_MIN; // Serration resets the inactive run.
                    end
                end
                default: begin
                    state_r <= SPMS_SEEK;
                    cnt_r   <= SEP_CNT_MIN;
                end
            endcase
        end
    end

    assign vsync_found = (state_r == SPMS_HELD);
    assign count       = cnt_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_detect_clears;
        @(posedge clk_sys) disable iff (!reset_n)
        (tick && state_r == SPMS_SEEK && cnt_r > threshold) |=> (cnt_r == 8'h00_00 && vsync_found);
    endproperty
    a_detect_clears: assert property (p_detect_clears) else $error("detect did not clear"); // [RQ8]

    property p_absence;
        @(posedge clk_sys) disable iff (!reset_n)
        (tick && state_r == SPMS_HELD && cnt_r >= threshold) |=> (!vsync_found && cnt_r == 8'h00_00);
    endproperty
    a_absence: assert property (p_absence) else $error("absence not declared"); // [RQ9]

    property p_no_wrap;
        @(posedge clk_sys) disable iff (!reset_n)
        !($past(cnt_r) == 8'h00_FF && cnt_r == 8'h00_00 && $past(state_r) == state_r);
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("counter wrapped"); // [RQ11]

    property p_count_up;
        @(posedge clk_sys) disable iff (!reset_n)
        (tick && state_r == SPMS_SEEK && csync_active && cnt_r <= threshold && cnt_r != 8'h00_FF)
            |=> (cnt_r == $past(cnt_r) + 8'h00_01);
    endproperty
    a_count_up: assert property (p_count_up) else $error("no count up in pulse"); // [RQ6]

    property p_count_down;
        @(posedge clk_sys) disable iff (!reset_n)
        (tick && state_r == SPMS_SEEK && !csync_active && cnt_r <= threshold && cnt_r != 8'h00_00)
            |=> (cnt_r == $past(cnt_r) - 8'h00_01);
    endproperty
    a_count_down: assert property (p_count_down) else $error("no count down"); // [RQ6]

    property p_hold_no_tick;
        @(posedge clk_sys) disable iff (!reset_n)
        !tick |=> $stable(cnt_r);
    endproperty
    a_hold_no_tick: assert property (p_hold_no_tick) else $error("count moved off tick"); // [RQ4]

endmodule

// ### src/spms_top.sv
// Top of the sync path multiplexers with the vertical sync separator.
`timescale 1ns/1ps
// Operation
// [RQ1] Mux 1,2 pick hsync or green sync by 12H bit4; mux 3 coast/vsync by bit1.
// [RQ2] Mux 4 picks raw vsync or separator output by 12H bit 2.
// [RQ3] Mux 5,6,7 pick digital link or analog signals by 11H bit 3.
// [RQ4] Separator is an 8-bit counter stepped at 5 MHz, 200 ns per count.
// [RQ5] Separator ignores polarity; polarity is fixed ahead of it.
// [RQ6] Count up during sync pulse, down toward zero after it.
// [RQ7] Vsync present when count exceeds the programmable threshold.
// [RQ8] At detection clear counter, then count up while sync is inactive.
// [RQ9] Vsync absent when inactive count reaches the same threshold.
// [RQ10] After absence clear counter and restart detection.
// [RQ11] Counter saturates at 255 and never goes below zero.
module spms_top
    import spms_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic [7:0]           ctl_12h,
    input  wire logic [7:0]           ctl_11h,
    input  wire logic [SEP_CNT_W-1:0] sep_threshold,
    input  wire logic                 csync_invert,
    input  wire logic                 hsync_in,
    input  wire logic                 green_embedded_sync_input,
    input  wire logic                 vsync_in,
    input  wire logic                 coast_in,
    input  wire spms_link_t           digital_link,
    output spms_link_t                link_out,
    output logic                      hsync_path_out,
    output logic                      sep_src_out,
    output logic                      coast_path_out,
    output logic                      vsync_path_out,
    output logic                      vsync_found_out,
    output logic [SEP_CNT_W-1:0]      sep_count_out
);

    // ****************************************************************
    // Separator clock enable
    // ****************************************************************
    logic [SEP_DIV_W-1:0] div_r;
    logic                 tick_r;

    // A one-cycle enable instead of a derived clock keeps the design on one domain.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else if (div_r == SEP_DIV_W'(SEP_DIV_COUNT - 1)) begin
            div_r  <= '0;
            tick_r <= 1'b1; // [RQ4]
        end else begin
            div_r  <= div_r + SEP_DIV_W'(1);
            tick_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Sync source selection
    // ****************************************************************
    logic mux1;
    logic csync_pol;
    logic sep_vsync;
    logic [SEP_CNT_W-1:0] sep_cnt;

    assign mux1 = ctl_12h[CTL12_GREEN_SEL_BIT] ? green_embedded_sync_input : hsync_in; // [RQ1]
    // Polarity is normalised here so the separator sees active high only.
    assign csync_pol = mux1 ^ csync_invert; // [RQ5]

    spms_separator u_sep (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .tick         (tick_r),
        .csync_active (csync_pol),
        .threshold    (sep_threshold),
        .vsync_found  (sep_vsync),
        .count        (sep_cnt)
    );

    // ****************************************************************
    // Registered outputs
    // ****************************************************************

    // Analog path outputs; one cycle of latency is the price of registered outputs.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hsync_path_out  <= 1'b0;
            sep_src_out     <= 1'b0;
            coast_path_out  <= 1'b0;
            vsync_path_out  <= 1'b0;
            vsync_found_out <= 1'b0;
            sep_count_out   <= '0;
        end else begin
            hsync_path_out  <= mux1; // [RQ1]
            sep_src_out     <= mux1; // [RQ1]
            coast_path_out  <= ctl_12h[CTL12_COAST_SEL_BIT] ? vsync_in : coast_in; // [RQ1]
            vsync_path_out  <= ctl_12h[CTL12_VSYNC_SEL_BIT] ? sep_vsync : vsync_in; // [RQ2]
            vsync_found_out <= sep_vsync;
            sep_count_out   <= sep_cnt;
        end
    end

    // Link selection for the output stage.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            link_out <= '0;
        end else if (ctl_11h[CTL11_ANALOG_SEL_BIT]) begin
            link_out.hsync   <= mux1; // [RQ3]
            link_out.vsync   <= ctl_12h[CTL12_VSYNC_SEL_BIT] ? sep_vsync : vsync_in;
            link_out.data_en <= ~coast_in;
        end else begin
            link_out <= digital_link; // [RQ3]
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_mux1;
        @(posedge clk_sys) disable iff (!reset_n)
        ##1 (hsync_path_out == $past(ctl_12h[4] ? green_embedded_sync_input : hsync_in));
    endproperty
    a_mux1: assert property (p_mux1) else $error("mux 1 wrong source"); // [RQ1]

    property p_mux4;
        @(posedge clk_sys) disable iff (!reset_n)
        ##1 (vsync_path_out == $past(ctl_12h[2] ? sep_vsync : vsync_in));
    endproperty
    a_mux4: assert property (p_mux4) else $error("mux 4 wrong source"); // [RQ2]

    property p_mux_link;
        @(posedge clk_sys) disable iff (!reset_n)
        (!ctl_11h[3]) |=> (link_out == $past(digital_link));
    endproperty
    a_mux_link: assert property (p_mux_link) else $error("digital link not passed"); // [RQ3]

    // Seven quiet cycles between enables give the 5 MHz step.
    sequence s_tick_gap;
        (!tick_r) [*7];
    endsequence

    property p_tick_period;
        @(posedge clk_sys) disable iff (!reset_n)
        tick_r |=> s_tick_gap ##1 tick_r;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period not 8"); // [RQ4]

    // ****************************************************************
    // Output stage checks
    // ****************************************************************

    // The second copy of the first stage feeds the separator path.
    property p_mux2;
        @(posedge clk_sys) disable iff (!reset_n)
        ##1 (sep_src_out == $past(mux1));
    endproperty
    a_mux2: assert property (p_mux2) else $error("mux 2 wrong source"); // [RQ1]

    // Both first-stage copies must always agree, or the two paths drift apart.
    property p_mux_pair;
        @(posedge clk_sys) disable iff (!reset_n)
        hsync_path_out == sep_src_out;
    endproperty
    a_mux_pair: assert property (p_mux_pair) else $error("mux 1 and 2 differ"); // [RQ1]

    // The coast path picks coast or vertical sync.
    property p_mux3;
        @(posedge clk_sys) disable iff (!reset_n)
        ##1 (coast_path_out == $past(ctl_12h[CTL12_COAST_SEL_BIT] ? vsync_in : coast_in));
    endproperty
    a_mux3: assert property (p_mux3) else $error("mux 3 wrong source"); // [RQ1]

    // The analog link takes its horizontal sync from the first stage.
    property p_link_hsync;
        @(posedge clk_sys) disable iff (!reset_n)
        ctl_11h[CTL11_ANALOG_SEL_BIT] |=> (link_out.hsync == $past(mux1));
    endproperty
    a_link_hsync: assert property (p_link_hsync) else $error("analog hsync not passed"); // [RQ3]

    // The analog link vertical sync follows the fourth stage selection.
    property p_link_vsync;
        @(posedge clk_sys) disable iff (!reset_n)
        ctl_11h[CTL11_ANALOG_SEL_BIT]
            |=> (link_out.vsync == $past(ctl_12h[CTL12_VSYNC_SEL_BIT] ? sep_vsync : vsync_in));
    endproperty
    a_link_vsync: assert property (p_link_vsync) else $error("analog vsync not passed"); // [RQ3]

    // The analog data enable is the inverse of coast.
    property p_link_den;
        @(posedge clk_sys) disable iff (!reset_n)
        ctl_11h[CTL11_ANALOG_SEL_BIT] |=> (link_out.data_en == !$past(coast_in));
    endproperty
    a_link_den: assert property (p_link_den) else $error("analog data enable wrong"); // [RQ3]

    // With the separator selected, the vertical path shows the separator state.
    property p_path_uses_sep;
        @(posedge clk_sys) disable iff (!reset_n)
        ctl_12h[CTL12_VSYNC_SEL_BIT] |=> (vsync_path_out == vsync_found_out);
    endproperty
    a_path_uses_sep: assert property (p_path_uses_sep) else $error("sep not on path"); // [RQ2]

    // The presence flag reaches the pin one cycle after the separator decides.
    property p_found_out;
        @(posedge clk_sys) disable iff (!reset_n)
        ##1 (vsync_found_out == $past(sep_vsync));
    endproperty
    a_found_out: assert property (p_found_out) else $error("presence flag lags"); // [RQ7]

    // The count copy is registered once more for the pins.
    property p_count_out;
        @(posedge clk_sys) disable iff (!reset_n)
        ##1 (sep_count_out == $past(sep_cnt));
    endproperty
    a_count_out: assert property (p_count_out) else $error("count copy wrong"); // [RQ4]

    // The divider wraps after its last count and fires the enable once.
    property p_div_wrap;
        @(posedge clk_sys) disable iff (!reset_n)
        (div_r == SEP_DIV_W'(SEP_DIV_COUNT - 1)) |=> (tick_r && div_r == '0);
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap"); // [RQ4]

    // The separator decides only on an enable, never between them.
    property p_state_on_tick;
        @(posedge clk_sys) disable iff (!reset_n)
        !tick_r |=> $stable(sep_vsync);
    endproperty
    a_state_on_tick: assert property (p_state_on_tick) else $error("state moved off tick"); // [RQ4]

endmodule
